// ---- pkg/sbt_defs.svh ----
`ifndef SBT_DEFS_SVH
`define SBT_DEFS_SVH

// ----------------------------------------------------------------
// instruction codes
// ----------------------------------------------------------------
`define SBT_IR_WIDTH        3
`define SBT_IR_EXTEST       3'h0
`define SBT_IR_IDCODE       3'h1
`define SBT_IR_SAMPLEZ      3'h2
`define SBT_IR_SAMPLE       3'h4
`define SBT_IR_BYPASS       3'h7
`define SBT_IR_CAPTURE      3'h1

// ----------------------------------------------------------------
// scan chain sizes and reset values
// ----------------------------------------------------------------
`define SBT_BS_CELLS        89
`define SBT_BS_RING         88
`define SBT_BS_CTRL_CELL    88
`define SBT_BS_RESET        89'h100_0000_0000_0000_0000_0000
`define SBT_NC_MASK         88'h0
`define SBT_ID_WIDTH        32

// ----------------------------------------------------------------
// identification fields, values arbitrary
// ----------------------------------------------------------------
`define SBT_ID_REV          3'h5
`define SBT_ID_DEVICE       17'h0a5a5
`define SBT_ID_MAKER        11'h2aa

// ----------------------------------------------------------------
// apb register byte offsets and field positions
// ----------------------------------------------------------------
`define SBT_REG_CTRL        12'h000
`define SBT_REG_STATUS      12'h004
`define SBT_REG_EVENT       12'h008
`define SBT_REG_IDWORD      12'h00c
`define SBT_CTRL_RESET      1'h0
`define SBT_STAT_OVF_BIT    8
`define SBT_EVT_VALID_BIT   16

// ----------------------------------------------------------------
// event log
// ----------------------------------------------------------------
`define SBT_LOG_WIDTH       16
`define SBT_LOG_DEPTH       8
`define SBT_SYNC_WIDTH      91

`endif

// ---- pkg/sbt_pkg.sv ----
`default_nettype none

package sbt_pkg;

    typedef enum logic [3:0]
    {
        sTlr, sRti, sSelDr, sCapDr, sShDr, sEx1Dr, sPauDr, sEx2Dr, sUpdDr,
        sSelIr, sCapIr, sShIr, sEx1Ir, sPauIr, sEx2Ir, sUpdIr
    } sbt_tap_state_t;

    typedef enum logic [1:0]
    {
        selBypass, selIdent, selBoundary
    } sbt_dr_sel_t;

endpackage : sbt_pkg

`default_nettype wire

// ---- pkg/sbt_stream_if.sv ----
`default_nettype none

interface sbt_stream_if #(parameter int WIDTH = 16);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface : sbt_stream_if

`default_nettype wire

// ---- rtl/sbt_sync.sv ----
`default_nettype none

module sbt_sync #(parameter int WIDTH = 1)
(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async,
    output var  logic [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta   <= '0;
            synced <= '0;
        end
        else
        begin
            meta   <= async;
            synced <= meta;
        end
    end
endmodule : sbt_sync

`default_nettype wire

// ---- rtl/sbt_fifo.sv ----
`default_nettype none

module sbt_fifo #(parameter int WIDTH = 16, parameter int DEPTH = 8)
(
    input  wire logic  clk,
    input  wire logic  rst_n,
    sbt_stream_if.sink   wr,
    sbt_stream_if.source rd
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr;
    logic [AW-1:0]    rdPtr;
    logic [AW:0]      count;
    logic             doPush;
    logic             doPop;

    assign wr.ready = (count != (AW+1)'(DEPTH));
    assign rd.valid = (count != '0);
    assign rd.data  = mem[rdPtr];
    assign doPush   = wr.valid && wr.ready;
    assign doPop    = rd.valid && rd.ready;

    always_ff @(posedge clk)
    begin
        if (doPush)
            mem[wrPtr] <= wr.data;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end
        else
        begin
            if (doPush)
                wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
            if (doPop)
                rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
            if (doPush && !doPop)
                count <= count + 1'b1;
            else if (doPop && !doPush)
                count <= count - 1'b1;
        end
    end
endmodule : sbt_fifo

`default_nettype wire

// ---- rtl/sbt_tap_top.sv ----
// Notes on behaviour
// R1: boundary chain holds 89 cells between serial input and output when selected.
// R2: id bits 31:29 revision, 28:12 device code, both fixed.
// R3: id bits 11:1 hold the fixed maker code.
// R4: id bit 0 always reads one.
// R5: code 000 captures ring, selects boundary chain, memory output enable follows latched cell 89.
// R6: code 001 loads and selects the identification register, memory unaffected.
// R7: code 010 captures ring, selects boundary chain, forces outputs high impedance.
// R8: code 100 captures ring and selects boundary chain, memory unaffected.
// R9: code 111 selects the one-bit bypass register, memory unaffected.
// R10: controller never loads codes 011, 101, 110; ir takes any code from irShift, and these three select bypass.
// R11: cells of unconnected balls capture a fixed low.
// R12: cell 89 presets high.
// R13: three-bit instruction register captures 01 in low bits, resets to IDCODE.
// R14: five rising test clocks with mode high reset the port, memory unaffected.
// R15: serial input sampled on rising test clock, output changes on falling.
// R16: under 000 the latched cell 89 enables outputs; presets high in reset.
// R17: sixteen-state controller follows the standard mode-select transitions.
// R18: serial output high impedance whenever no register is shifting.
`include "sbt_defs.svh"
`default_nettype none

module sbt_tap_top #(
    parameter logic [2:0]  ID_REV    = `SBT_ID_REV,
    parameter logic [16:0] ID_DEVICE = `SBT_ID_DEVICE,
    parameter logic [10:0] ID_MAKER  = `SBT_ID_MAKER,
    parameter int          LOG_DEPTH = `SBT_LOG_DEPTH
)
(
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic                      tck,
    input  wire logic                      tms,
    input  wire logic                      tdi,
    output var  logic                      tdo,
    output var  logic                      tdoOe,
    input  wire logic [`SBT_BS_RING-1:0]   ringIn,
    output var  logic [`SBT_BS_CELLS-1:0]  ringOut,
    output var  logic                      extestActive,
    output var  logic                      memOutEn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output var  logic [31:0]               prdata,
    output var  logic                      pready,
    output var  logic                      pslverr
);
    import sbt_pkg::*;

    // ----------------------------------------------------------------
    // input synchronisers and test clock edges
    // ----------------------------------------------------------------
    logic [`SBT_SYNC_WIDTH-1:0] syncOut;
    logic                       tckS;
    logic                       tmsS;
    logic                       tdiS;
    logic [`SBT_BS_RING-1:0]    ringS;
    logic                       tckDly;
    logic                       tckRise;
    logic                       tckFall;

    sbt_sync #(.WIDTH(`SBT_SYNC_WIDTH)) uSync
    (
        .clk    (clk),
        .rst_n  (rst_n),
        .async  ({ringIn, tdi, tms, tck}),
        .synced (syncOut)
    );

    assign tckS  = syncOut[0];
    assign tmsS  = syncOut[1];
    assign tdiS  = syncOut[2];
    assign ringS = syncOut[`SBT_SYNC_WIDTH-1:3];

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            tckDly <= 1'b0;
        else
            tckDly <= tckS;
    end

    assign tckRise = tckS && !tckDly;
    assign tckFall = !tckS && tckDly;

    // ----------------------------------------------------------------
    // controller state
    // ----------------------------------------------------------------
    sbt_tap_state_t state;
    sbt_tap_state_t next_state;

    always_comb
    begin
        next_state = state;
        case (state)
            sTlr:    next_state = tmsS ? sTlr   : sRti;
            sRti:    next_state = tmsS ? sSelDr : sRti;
            sSelDr:  next_state = tmsS ? sSelIr : sCapDr;
            sCapDr:  next_state = tmsS ? sEx1Dr : sShDr;
            sShDr:   next_state = tmsS ? sEx1Dr : sShDr;
            sEx1Dr:  next_state = tmsS ? sUpdDr : sPauDr;
            sPauDr:  next_state = tmsS ? sEx2Dr : sPauDr;
            sEx2Dr:  next_state = tmsS ? sUpdDr : sShDr;
            sUpdDr:  next_state = tmsS ? sSelDr : sRti;
            sSelIr:  next_state = tmsS ? sTlr   : sCapIr;
            sCapIr:  next_state = tmsS ? sEx1Ir : sShIr;
            sShIr:   next_state = tmsS ? sEx1Ir : sShIr;
            sEx1Ir:  next_state = tmsS ? sUpdIr : sPauIr;
            sPauIr:  next_state = tmsS ? sEx2Ir : sPauIr;
            sEx2Ir:  next_state = tmsS ? sUpdIr : sShIr;
            sUpdIr:  next_state = tmsS ? sSelDr : sRti;
            default: next_state = sTlr;
        endcase
    end

    // five high mode bits from any state reach reset through the table above
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            state <= sTlr;
        else if (tckRise)
            state <= next_state; // R17 R14 R15
    end

    // ----------------------------------------------------------------
    // instruction register
    // ----------------------------------------------------------------
    logic [`SBT_IR_WIDTH-1:0] irShift;
    logic [`SBT_IR_WIDTH-1:0] ir;
    sbt_dr_sel_t              drSel;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            irShift <= `SBT_IR_CAPTURE;
        else if (tckRise && state == sCapIr)
            irShift <= `SBT_IR_CAPTURE; // R13
        else if (tckRise && state == sShIr)
            irShift <= {tdiS, irShift[`SBT_IR_WIDTH-1:1]}; // R15
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ir <= `SBT_IR_IDCODE;
        else if (state == sTlr)
            ir <= `SBT_IR_IDCODE; // R13
        else if (tckFall && state == sUpdIr)
            ir <= irShift;
    end

    // unused codes fall back to bypass so the chain stays one bit long
    always_comb
    begin
        drSel = selBypass; // R9 R10
        if (ir == `SBT_IR_EXTEST || ir == `SBT_IR_SAMPLEZ || ir == `SBT_IR_SAMPLE)
            drSel = selBoundary; // R5 R7 R8
        else if (ir == `SBT_IR_IDCODE)
            drSel = selIdent; // R6
    end

    // ----------------------------------------------------------------
    // data registers
    // ----------------------------------------------------------------
    logic                      bypassBit;
    logic [`SBT_ID_WIDTH-1:0]  idShift;
    logic [`SBT_ID_WIDTH-1:0]  idWord;
    logic [`SBT_BS_CELLS-1:0]  bsShift;
    logic [`SBT_BS_CELLS-1:0]  bsLatch;
    logic                      drOut;

    assign idWord = {ID_REV, ID_DEVICE, ID_MAKER, 1'b1}; // R2 R3 R4

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            bypassBit <= 1'b0;
        else if (tckRise && state == sCapDr && drSel == selBypass)
            bypassBit <= 1'b0; // R9
        else if (tckRise && state == sShDr && drSel == selBypass)
            bypassBit <= tdiS;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            idShift <= '0;
        else if (tckRise && state == sCapDr && drSel == selIdent)
            idShift <= idWord; // R6
        else if (tckRise && state == sShDr && drSel == selIdent)
            idShift <= {tdiS, idShift[`SBT_ID_WIDTH-1:1]};
    end

    // cell 1 sits next to the serial output, the control cell next to the input
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            bsShift <= `SBT_BS_RESET;
        else if (tckRise && state == sCapDr && drSel == selBoundary)
            bsShift <= {bsLatch[`SBT_BS_CTRL_CELL], ringS & ~`SBT_NC_MASK}; // R5 R7 R8 R11
        else if (tckRise && state == sShDr && drSel == selBoundary)
            bsShift <= {tdiS, bsShift[`SBT_BS_CELLS-1:1]}; // R1
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            bsLatch <= `SBT_BS_RESET; // R12 R16
        else if (state == sTlr)
            bsLatch[`SBT_BS_CTRL_CELL] <= 1'b1; // R16
        else if (tckFall && state == sUpdDr && drSel == selBoundary)
            bsLatch <= bsShift;
    end

    always_comb
    begin
        drOut = bypassBit;
        case (drSel)
            selIdent:    drOut = idShift[0];
            selBoundary: drOut = bsShift[0];
            default:     drOut = bypassBit;
        endcase
    end

    // ----------------------------------------------------------------
    // serial output and pin control
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tdo   <= 1'b0;
            tdoOe <= 1'b0; // R18
        end
        else if (tckFall)
        begin
            if (state == sShIr)
            begin
                tdo   <= irShift[0]; // R15
                tdoOe <= 1'b1;
            end
            else if (state == sShDr)
            begin
                tdo   <= drOut; // R15
                tdoOe <= 1'b1;
            end
            else
                tdoOe <= 1'b0; // R18
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            extestActive <= 1'b0;
            memOutEn     <= 1'b1;
            ringOut      <= `SBT_BS_RESET;
        end
        else
        begin
            ringOut      <= bsLatch;
            extestActive <= (ir == `SBT_IR_EXTEST); // R5
            if (ir == `SBT_IR_EXTEST)
                memOutEn <= bsLatch[`SBT_BS_CTRL_CELL]; // R16
            else if (ir == `SBT_IR_SAMPLEZ)
                memOutEn <= 1'b0; // R7
            else
                memOutEn <= 1'b1; // R6 R8 R9 R14
        end
    end

    // ----------------------------------------------------------------
    // update event log
    // ----------------------------------------------------------------
    sbt_stream_if #(.WIDTH(`SBT_LOG_WIDTH)) logIn ();
    sbt_stream_if #(.WIDTH(`SBT_LOG_WIDTH)) logOut ();

    logic                      logEnable;
    logic                      pendValid;
    logic [`SBT_LOG_WIDTH-1:0] pendWord;
    logic                      updEvent;
    logic                      overflow;
    logic                      ovfSet;
    logic                      ovfClr;
    logic                      evtPop;

    assign updEvent = tckFall && logEnable && (state == sUpdIr || state == sUpdDr);
    assign ovfSet   = updEvent && pendValid && !logIn.ready;

    // one pending word waits for room; the fifo stalls it when full
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pendValid <= 1'b0;
            pendWord  <= '0;
        end
        else if (updEvent && (!pendValid || logIn.ready))
        begin
            pendValid <= 1'b1;
            if (state == sUpdIr)
                pendWord <= {1'b0, irShift, 12'h000};
            else
                pendWord <= {1'b1, ir, drSel == selIdent ? idShift[11:0] :
                             drSel == selBoundary ? bsShift[11:0] : {11'h000, bypassBit}};
        end
        else if (logIn.ready)
            pendValid <= 1'b0;
    end

    assign logIn.valid  = pendValid;
    assign logIn.data   = pendWord;
    assign logOut.ready = evtPop;

    sbt_fifo #(.WIDTH(`SBT_LOG_WIDTH), .DEPTH(LOG_DEPTH)) uLog
    (
        .clk   (clk),
        .rst_n (rst_n),
        .wr    (logIn),
        .rd    (logOut)
    );

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            overflow <= 1'b0;
        else if (ovfSet)
            overflow <= 1'b1;
        else if (ovfClr)
            overflow <= 1'b0;
    end

    // ----------------------------------------------------------------
    // apb slave, zero wait states
    // ----------------------------------------------------------------
    logic access;
    logic wrAcc;
    logic rdAcc;

    assign pready = 1'b1;
    assign access = psel && penable;
    assign wrAcc  = access && pwrite;
    assign rdAcc  = access && !pwrite;
    assign evtPop = rdAcc && paddr == `SBT_REG_EVENT && logOut.valid;
    assign ovfClr = wrAcc && paddr == `SBT_REG_STATUS && pwdata[`SBT_STAT_OVF_BIT];

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            logEnable <= `SBT_CTRL_RESET;
        else if (wrAcc && paddr == `SBT_REG_CTRL)
            logEnable <= pwdata[0];
    end

    always_comb
    begin
        prdata  = 32'h0000_0000;
        pslverr = 1'b0;
        if (paddr == `SBT_REG_CTRL)
            prdata = {31'h0000_0000, logEnable};
        else if (paddr == `SBT_REG_STATUS)
            prdata = {21'h00_0000, pendValid, logOut.valid, overflow, memOutEn, ir, state};
        else if (paddr == `SBT_REG_EVENT)
            prdata = {15'h0000, logOut.valid, logOut.valid ? logOut.data : 16'h0000};
        else if (paddr == `SBT_REG_IDWORD)
            prdata = idWord;
        else
            pslverr = access;
    end
endmodule : sbt_tap_top

`default_nettype wire

// ---- verif/sbt_tap_top_properties.sv ----
`include "sbt_defs.svh"
`default_nettype none

module sbt_tap_top_properties #(
    parameter logic [2:0]  ID_REV    = `SBT_ID_REV,
    parameter logic [16:0] ID_DEVICE = `SBT_ID_DEVICE,
    parameter logic [10:0] ID_MAKER  = `SBT_ID_MAKER,
    parameter int          LOG_DEPTH = `SBT_LOG_DEPTH
)
(
    input wire logic                     clk,
    input wire logic                     rst_n,
    input wire logic                     tck,
    input wire logic                     tms,
    input wire logic                     tdi,
    input wire logic                     tdo,
    input wire logic                     tdoOe,
    input wire logic [`SBT_BS_RING-1:0]  ringIn,
    input wire logic [`SBT_BS_CELLS-1:0] ringOut,
    input wire logic                     extestActive,
    input wire logic                     memOutEn,
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pwrite,
    input wire logic [11:0]              paddr,
    input wire logic [31:0]              pwdata,
    input wire logic [31:0]              prdata,
    input wire logic                     pready,
    input wire logic                     pslverr
);
    // ----------------------------------------------------------------
    // register reads tied to the id parameters and port outputs; port output checks at reset and on test clock edges
    // ----------------------------------------------------------------
    default clocking dcb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence idRd;
        psel && penable && !pwrite && paddr == 12'h00c;
    endsequence
    sequence statRd;
        psel && penable && !pwrite && paddr == 12'h004 && $stable(prdata[6:0]);
    endsequence

    AST_ID_HIGH: assert property (idRd |-> prdata[31:12] == {ID_REV, ID_DEVICE})
        else $error("id revision or device field wrong");
    AST_ID_MAKER: assert property (idRd |-> prdata[11:1] == ID_MAKER)
        else $error("id maker field wrong");
    AST_ID_PRESENT: assert property (idRd |-> prdata[0])
        else $error("id presence bit low");
    AST_TLR_IR: assert property (statRd ##0 prdata[3:0] == 4'h0 |-> prdata[6:4] == 3'h1)
        else $error("reset state without identify code");
    AST_EXTEST_PATH: assert property (statRd ##0 prdata[6:4] == 3'h0 |=> extestActive)
        else $error("all-zero code without external test path");
    AST_HIGHZ_CODE: assert property (statRd ##0 prdata[6:4] == 3'h2 |=> !memOutEn && !extestActive)
        else $error("high impedance code leaves outputs on");
    AST_TRANSPARENT: assert property (statRd ##0 prdata[6:4] inside {3'h1, 3'h4, 3'h7}
        |=> memOutEn && !extestActive)
        else $error("transparent code disturbs memory outputs");
    AST_CTRL_CELL: assert property (extestActive && $past(extestActive) && $stable(ringOut[88])
        |-> memOutEn == ringOut[88])
        else $error("output enable not following control cell");
    AST_RESET_CELL: assert property ($rose(rst_n) |-> ringOut == `SBT_BS_RESET && memOutEn)
        else $error("boundary latch reset value wrong");
    AST_RESET_TDO: assert property ($rose(rst_n) |-> !tdoOe && !tdo)
        else $error("serial output driven after reset");
    AST_TDO_FALL: assert property ($changed(tdo) |-> !tck)
        else $error("serial output changed while test clock high");
    AST_OE_FALL: assert property ($fell(tdoOe) |-> !tck)
        else $error("serial output released while test clock high");
endmodule : sbt_tap_top_properties

bind sbt_tap_top sbt_tap_top_properties #(.ID_REV(ID_REV), .ID_DEVICE(ID_DEVICE), .ID_MAKER(ID_MAKER),
    .LOG_DEPTH(LOG_DEPTH)) sbt_tap_top_properties_i (.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe), .ringIn(ringIn), .ringOut(ringOut), .extestActive(extestActive),
    .memOutEn(memOutEn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

`default_nettype wire

// ---- verif/sbt_jtag_model.sv ----
`default_nettype none

module sbt_jtag_model
(
    output var logic tck,
    output var logic tms,
    output var logic tdi,
    input wire logic tdoLine
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------------------------------
    // test controller, clock stands low between frames
    // ----------------------------------------------------------------
    logic junk;
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    task clockBit(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #62.5;
        q = tdoLine;
        tck = 1'b1;
        #62.5;
        tck = 1'b0;
    endtask : clockBit

    task tapReset();
        repeat (5) clockBit(1'b1, ~tdi, junk);
        clockBit(1'b0, ~tdi, junk);
    endtask : tapReset

    // from idle: through capture and shift, then update and back to idle
    task scan(input logic ir, input int n, input logic [127:0] din, output logic [127:0] dout);
        dout = '0;
        if (ir && din[2:0] inside {3'h3, 3'h5, 3'h6})
            return;
        clockBit(1'b1, ~tdi, junk);
        if (ir)
            clockBit(1'b1, ~tdi, junk);
        clockBit(1'b0, ~tdi, junk);
        clockBit(1'b0, ~tdi, junk);
        for (int i = 0; i < n; i++)
            clockBit(i == n - 1, din[i], dout[i]);
        clockBit(1'b1, ~tdi, junk);
        clockBit(1'b0, ~tdi, junk);
    endtask : scan
endmodule : sbt_jtag_model

`default_nettype wire

// ---- verif/sbt_tap_top_tb_top.sv ----
`include "sbt_defs.svh"
`default_nettype none

module sbt_tap_top_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct { logic [2:0] code; int len; logic memEn; logic ext; } sbt_row_t;
    localparam logic [31:0]  ID  = {`SBT_ID_REV, `SBT_ID_DEVICE, `SBT_ID_MAKER, 1'b1};
    localparam logic [127:0] PAT = {{120{1'b1}}, 8'ha6};

    logic         clk = 1'b0;
    logic         rst_n, psel, penable, pwrite, tdo, tdoOe, extestActive, memOutEn, pready, pslverr, e;
    wire logic    tck, tms, tdi;
    wire logic    tdoLine = tdoOe ? tdo : 1'b1;
    logic [87:0]  ringIn;
    logic [88:0]  ringOut;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, q;
    logic [127:0] dout;
    int           err_total, samples_checked;
    sbt_row_t     rows [5] = '{'{3'h4, 89, 1'b1, 1'b0}, '{3'h0, 89, 1'b1, 1'b1}, '{3'h2, 89, 1'b0, 1'b0},
                               '{3'h1, 32, 1'b1, 1'b0}, '{3'h7, 1, 1'b1, 1'b0}};

    always #4 clk = ~clk;

    sbt_tap_top sbt_tap_top_i (.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdoOe(tdoOe), .ringIn(ringIn), .ringOut(ringOut), .extestActive(extestActive), .memOutEn(memOutEn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    sbt_jtag_model sbt_jtag_model_i (.tck(tck), .tms(tms), .tdi(tdi), .tdoLine(tdoLine));

    // ----------------------------------------------------------------
    // compare, bus and closing tasks
    // ----------------------------------------------------------------
    task chkVal(input logic [127:0] g, input logic [127:0] x);
        samples_checked++;
        if (g !== x)
        begin
            $display("MISMATCH t=%0t exp=%h got=%h", $time, x, g);
            err_total++;
        end
    endtask : chkVal

    task chkBit(input logic g, input logic x);
        chkVal({127'h0, g}, {127'h0, x});
    endtask : chkBit

    task results();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic s);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        r = prdata;
        s = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20)
        begin
            err_total++;
            results();
        end
    endtask : apb

    task irLoad(input logic [2:0] c);
        sbt_jtag_model_i.scan(1'b1, 3, {125'h0, c}, dout);
    endtask : irLoad
    initial
    begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, ringIn, err_total, samples_checked} = '0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chkVal(ringOut, `SBT_BS_RESET);
        chkBit(tdoOe, 1'b0);
        apb(1'b0, 12'h004, 32'h0, q, e);
        chkVal(q[6:0], 7'h10);
        apb(1'b0, 12'h00c, 32'h0, q, e);
        chkVal(q, ID);
        sbt_jtag_model_i.tapReset();
        for (int i = 0; i < 5; i++)
        begin
            ringIn <= {11{8'h3c ^ 8'(i)}};
            irLoad(rows[i].code);
            chkVal(dout[1:0], 2'h1);
            chkBit(tdoOe, 1'b0);
            apb(1'b0, 12'h004, 32'h0, q, e);
            chkVal(q[7:4], {rows[i].memEn, rows[i].code});
            chkBit(extestActive, rows[i].ext);
            chkBit(memOutEn, rows[i].memEn);
            sbt_jtag_model_i.scan(1'b0, rows[i].len + 8, PAT, dout);
            chkVal(dout[rows[i].len +: 8], 8'ha6);
            if (rows[i].len == 32)
                chkVal(dout[31:0], ID);
            if (rows[i].len == 89)
                chkVal(dout[87:0], ringIn);
            if (rows[i].len == 1)
                chkBit(dout[0], 1'b0);
        end
        chkVal(ringOut, {89{1'b1}});
        // event log: overfill, then drain
        apb(1'b1, 12'h000, 32'h1, q, e);
        repeat (10) irLoad(3'h7);
        apb(1'b0, 12'h004, 32'h0, q, e);
        chkBit(q[8], 1'b1);
        repeat (9)
        begin
            apb(1'b0, 12'h008, 32'h0, q, e);
            chkVal(q[16:0], 17'h17000);
        end
        apb(1'b0, 12'h008, 32'h0, q, e);
        chkBit(q[16], 1'b0);
        apb(1'b1, 12'h004, 32'h100, q, e);
        apb(1'b0, 12'h004, 32'h0, q, e);
        chkBit(q[8], 1'b0);
        apb(1'b1, 12'h000, 32'h0, q, e);
        apb(1'b0, 12'h010, 32'h0, q, e);
        chkBit(e, 1'b1);
        chkVal(q, 32'h0);
        // control cell cleared, then restored by a test reset
        irLoad(3'h0);
        sbt_jtag_model_i.scan(1'b0, 89, 128'h0, dout);
        chkBit(memOutEn, 1'b0);
        chkVal(ringOut, 89'h0);
        sbt_jtag_model_i.tapReset();
        chkBit(ringOut[88], 1'b1);
        chkVal(ringOut[87:0], 88'h0);
        apb(1'b0, 12'h004, 32'h0, q, e);
        chkVal(q[7:4], 4'h9);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chkVal(ringOut, `SBT_BS_RESET);
        results();
    end
endmodule : sbt_tap_top_tb_top

`default_nettype wire
